// File: hw/mirqr_regs.sv
`timescale 1ns/1ps
// Function
// - An 8-bit interrupt status register holds FIFO full, empty, overflow, underflow, digital lock, analog lock and reset done in bits 6 to 0, bit 7 unused, all reset to 0.
// - An 8-bit interrupt enable register matches the status bits one for one, bit 7 unused, reset to 0.
// - A 32-bit carrier oscillator phase increment resets to zero and sets the carrier step.
// - A 32-bit symbol oscillator phase increment resets to zero and sets the symbol rate step.
// - A 32-bit loop filter upper clamp resets to 7FFFFFF hex.
// - A 32-bit loop filter lower clamp resets to zero.
// - Any write to control word 0x0E gives a one-cycle FIFO clear pulse.
// - Any write to control word 0x0F gives an update pulse copying a holding register byte into the staging buffer.
// - Writing 0x10 to address 4 raises soft reset, which stays until another value is written there.
// - A 19-bit seed at control word 0x11 preloads the shaping filter accumulators.
// - A write to control word 0x12 enables loading strobed 16-bit samples into the FIFO.
module mirqr_regs #(
	parameter int SAMPLE_W = mirqr_pkg::SAMPLE_W,
	parameter int SEED_W = mirqr_pkg::SEED_W
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic clk_en_i,
	// host control interface pins
	input wire logic host_ce_n_i,
	input wire logic host_wr_n_i,
	input wire logic [2:0] host_addr_i,
	input wire logic [7:0] control_data_bus_i,
	output logic [7:0] control_data_bus_o,
	output logic control_data_bus_oe_o,
	// sample input pins
	input wire logic [SAMPLE_W-1:0] sample_bus_i,
	input wire logic input_sample_strobe_i,
	output logic sample_ready_o,
	// events from the datapath, same clock
	input wire logic [6:1] status_event_i,
	// fields to the datapath
	output logic [31:0] carrier_inc_o,
	output logic [31:0] symbol_inc_o,
	output logic [31:0] upper_clamp_o,
	output logic [31:0] lower_clamp_o,
	output logic [SEED_W-1:0] accumulator_seed_o,
	output logic [31:0] staging_buffer_o,
	output logic fifo_clear_pulse_o,
	output logic staging_update_pulse_o,
	output logic soft_reset_o,
	output logic irq_o,
	// sample stream toward the fifo
	output logic [SAMPLE_W-1:0] fifo_data_o,
	output logic fifo_valid_o,
	input wire logic fifo_ready_i
);
	localparam int PIN_W = 1 + 1 + 3 + 8 + 1 + SAMPLE_W;

	logic [PIN_W-1:0] pin_meta_r;
	logic [PIN_W-1:0] pin_sync_r;
	logic ce_n_s;
	logic wr_n_s;
	logic [2:0] addr_s;
	logic [7:0] data_s;
	logic strb_s;
	logic [SAMPLE_W-1:0] din_s;
	logic wr_n_d_r;
	logic strb_d_r;
	logic host_write;
	logic xfer_write;
	logic [7:0] cw_num;
	logic [7:0] hold_r [4];
	logic [31:0] hold_word;
	logic [7:0] sel_word_r;
	logic [7:0] irq_status_r;
	logic [7:0] irq_status_nxt;
	logic [7:0] irq_enable_r;
	logic [31:0] carrier_inc_r;
	logic [31:0] symbol_inc_r;
	logic [31:0] upper_clamp_r;
	logic [31:0] lower_clamp_r;
	logic [SEED_W-1:0] seed_r;
	logic fifo_clear_r;
	logic update_r;
	logic soft_reset_r;
	logic soft_reset_d_r;
	logic [1:0] byte_ptr_r;
	logic [31:0] staging_r;
	logic load_en_r;
	logic [31:0] read_word;
	logic [7:0] read_byte;
	logic [7:0] rdata_r;
	logic rd_oe_r;
	logic [SAMPLE_W-1:0] buf_data_r [2];
	logic buf_wp_r;
	logic buf_rp_r;
	logic [1:0] buf_cnt_r;
	logic buf_in_valid;
	logic buf_in_ready;
	logic buf_push;
	logic buf_pop;

	// two-flop synchroniser for every pin input
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pin_meta_r <= {1'b1, 1'b1, {(PIN_W-2){1'b0}}};
			pin_sync_r <= {1'b1, 1'b1, {(PIN_W-2){1'b0}}};
		end
		else if (clk_en_i)
		begin
			pin_meta_r <= {host_ce_n_i, host_wr_n_i, host_addr_i, control_data_bus_i,
				input_sample_strobe_i, sample_bus_i};
			pin_sync_r <= pin_meta_r;
		end
	end

	// unpack synchronised pins
	assign {ce_n_s, wr_n_s, addr_s, data_s, strb_s, din_s} = pin_sync_r;

	// delayed copies for edge detection
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			wr_n_d_r <= 1'b1;
			strb_d_r <= 1'b0;
		end
		else if (clk_en_i)
		begin
			wr_n_d_r <= wr_n_s;
			strb_d_r <= strb_s;
		end
	end

	// a write completes on the rising edge of the write strobe
	assign host_write = wr_n_s & ~wr_n_d_r & ~ce_n_s;
	assign xfer_write = host_write && (addr_s == mirqr_pkg::HADDR_XFER);
	assign cw_num = data_s;
	assign hold_word = {hold_r[3], hold_r[2], hold_r[1], hold_r[0]};

	// holding register bytes at host addresses 0 to 3
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			for (int i = 0; i < 4; i++)
			begin
				hold_r[i] <= 8'h00;
			end
		end
		else if (clk_en_i && host_write && addr_s <= mirqr_pkg::HADDR_HOLD3)
		begin
			hold_r[addr_s[1:0]] <= data_s;
		end
	end

	// word selected for readback follows the last transfer
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sel_word_r <= mirqr_pkg::CW_IRQ_STATUS;
		end
		else if (clk_en_i && xfer_write)
		begin
			sel_word_r <= cw_num;
		end
	end

	// sticky status; a new event wins over a clear in the same cycle
	always_comb
	begin
		irq_status_nxt = irq_status_r;
		if (xfer_write && cw_num == mirqr_pkg::CW_IRQ_STATUS)
		begin
			irq_status_nxt = irq_status_nxt & ~hold_r[0];
		end
		irq_status_nxt[6:1] = irq_status_nxt[6:1] | status_event_i;
		if (soft_reset_d_r && !soft_reset_r)
		begin
			irq_status_nxt[mirqr_pkg::BIT_RESET_DONE] = 1'b1;
		end
		irq_status_nxt = irq_status_nxt & mirqr_pkg::IRQ_USED_MASK;
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			irq_status_r <= mirqr_pkg::RST_IRQ_STATUS;
		end
		else if (clk_en_i)
		begin
			irq_status_r <= irq_status_nxt;
		end
	end

	// writable configuration words
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			irq_enable_r <= mirqr_pkg::RST_IRQ_ENABLE;
			carrier_inc_r <= mirqr_pkg::RST_CARRIER_INC;
			symbol_inc_r <= mirqr_pkg::RST_SYMBOL_INC;
			upper_clamp_r <= mirqr_pkg::RST_UPPER_CLAMP;
			lower_clamp_r <= mirqr_pkg::RST_LOWER_CLAMP;
			seed_r <= SEED_W'(mirqr_pkg::RST_SHAPING_SEED);
		end
		else if (clk_en_i && xfer_write)
		begin
			case (cw_num)
				mirqr_pkg::CW_IRQ_ENABLE: irq_enable_r <= hold_r[0] & mirqr_pkg::IRQ_USED_MASK;
				mirqr_pkg::CW_CARRIER_INC: carrier_inc_r <= hold_word;
				mirqr_pkg::CW_SYMBOL_INC: symbol_inc_r <= hold_word;
				mirqr_pkg::CW_UPPER_CLAMP: upper_clamp_r <= hold_word;
				mirqr_pkg::CW_LOWER_CLAMP: lower_clamp_r <= hold_word;
				mirqr_pkg::CW_SHAPING_SEED: seed_r <= hold_word[SEED_W-1:0];
				default: ;
			endcase
		end
	end

	// one-cycle strobes decoded from control word transfers
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			fifo_clear_r <= 1'b0;
			update_r <= 1'b0;
		end
		else if (clk_en_i)
		begin
			fifo_clear_r <= xfer_write && cw_num == mirqr_pkg::CW_FIFO_CLEAR;
			update_r <= xfer_write && cw_num == mirqr_pkg::CW_STAGING_UPDATE;
		end
	end

	// soft reset level held by the last value written to address 4
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			soft_reset_r <= 1'b0;
			soft_reset_d_r <= 1'b0;
		end
		else if (clk_en_i)
		begin
			if (xfer_write)
			begin
				soft_reset_r <= (data_s == mirqr_pkg::SOFT_RESET_CODE);
			end
			soft_reset_d_r <= soft_reset_r;
		end
	end

	// staging buffer fills one byte per update, lowest byte first
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			byte_ptr_r <= 2'd0;
			staging_r <= 32'h0000_0000;
		end
		else if (clk_en_i)
		begin
			if (soft_reset_r)
			begin
				byte_ptr_r <= 2'd0;
			end
			else if (update_r)
			begin
				staging_r[byte_ptr_r*8 +: 8] <= hold_r[byte_ptr_r];
				byte_ptr_r <= byte_ptr_r + 2'd1;
			end
		end
	end

	// sample loading armed by its strobe word, disarmed by fifo clear or soft reset
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			load_en_r <= 1'b0;
		end
		else if (clk_en_i)
		begin
			if (xfer_write && cw_num == mirqr_pkg::CW_SAMPLE_LOAD)
			begin
				load_en_r <= 1'b1;
			end
			else if (fifo_clear_r || soft_reset_r)
			begin
				load_en_r <= 1'b0;
			end
		end
	end

	// two-entry buffer between sample pins and fifo
	assign buf_in_valid = load_en_r & strb_s & ~strb_d_r;
	assign buf_in_ready = (buf_cnt_r != 2'd2);
	assign buf_push = buf_in_valid & buf_in_ready;
	assign buf_pop = fifo_valid_o & fifo_ready_i;
	assign fifo_valid_o = (buf_cnt_r != 2'd0);
	assign fifo_data_o = buf_data_r[buf_rp_r];
	assign sample_ready_o = buf_in_ready & load_en_r;

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			buf_wp_r <= 1'b0;
			buf_rp_r <= 1'b0;
			buf_cnt_r <= 2'd0;
			buf_data_r[0] <= '0;
			buf_data_r[1] <= '0;
		end
		else if (clk_en_i)
		begin
			if (fifo_clear_r)
			begin
				buf_wp_r <= 1'b0;
				buf_rp_r <= 1'b0;
				buf_cnt_r <= 2'd0;
			end
			else
			begin
				if (buf_push)
				begin
					buf_data_r[buf_wp_r] <= din_s;
					buf_wp_r <= ~buf_wp_r;
				end
				if (buf_pop)
				begin
					buf_rp_r <= ~buf_rp_r;
				end
				case ({buf_push, buf_pop})
					2'b10: buf_cnt_r <= buf_cnt_r + 2'd1;
					2'b01: buf_cnt_r <= buf_cnt_r - 2'd1;
					default: ;
				endcase
			end
		end
	end

	// readback of the selected word, byte chosen by host address
	always_comb
	begin
		case (sel_word_r)
			mirqr_pkg::CW_IRQ_STATUS: read_word = {24'h00_0000, irq_status_r};
			mirqr_pkg::CW_IRQ_ENABLE: read_word = {24'h00_0000, irq_enable_r};
			mirqr_pkg::CW_CARRIER_INC: read_word = carrier_inc_r;
			mirqr_pkg::CW_SYMBOL_INC: read_word = symbol_inc_r;
			mirqr_pkg::CW_UPPER_CLAMP: read_word = upper_clamp_r;
			mirqr_pkg::CW_LOWER_CLAMP: read_word = lower_clamp_r;
			mirqr_pkg::CW_SHAPING_SEED: read_word = {{(32-SEED_W){1'b0}}, seed_r};
			default: read_word = 32'h0000_0000;
		endcase
		if (addr_s == mirqr_pkg::HADDR_XFER)
		begin
			read_byte = sel_word_r;
		end
		else if (addr_s <= mirqr_pkg::HADDR_HOLD3)
		begin
			read_byte = read_word[addr_s[1:0]*8 +: 8];
		end
		else
		begin
			read_byte = 8'h00;
		end
	end

	// data bus driven while selected and not writing
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rdata_r <= 8'h00;
			rd_oe_r <= 1'b0;
		end
		else if (clk_en_i)
		begin
			rdata_r <= read_byte;
			rd_oe_r <= ~ce_n_s & wr_n_s;
		end
	end

	// outputs
	assign control_data_bus_o = rdata_r;
	assign control_data_bus_oe_o = rd_oe_r;
	assign carrier_inc_o = carrier_inc_r;
	assign symbol_inc_o = symbol_inc_r;
	assign upper_clamp_o = upper_clamp_r;
	assign lower_clamp_o = lower_clamp_r;
	assign accumulator_seed_o = seed_r;
	assign staging_buffer_o = staging_r;
	assign fifo_clear_pulse_o = fifo_clear_r;
	assign staging_update_pulse_o = update_r;
	assign soft_reset_o = soft_reset_r;
	assign irq_o = |(irq_status_r & irq_enable_r);
endmodule

// File: shared/mirqr_pkg.sv
package mirqr_pkg;
	// host interface address spaces
	localparam logic [2:0] HADDR_HOLD0 = 3'h0;
	localparam logic [2:0] HADDR_HOLD3 = 3'h3;
	localparam logic [2:0] HADDR_XFER = 3'h4;
	// control word numbers
	localparam logic [7:0] CW_IRQ_STATUS = 8'h08;
	localparam logic [7:0] CW_IRQ_ENABLE = 8'h09;
	localparam logic [7:0] CW_CARRIER_INC = 8'h0a;
	localparam logic [7:0] CW_SYMBOL_INC = 8'h0b;
	localparam logic [7:0] CW_UPPER_CLAMP = 8'h0c;
	localparam logic [7:0] CW_LOWER_CLAMP = 8'h0d;
	localparam logic [7:0] CW_FIFO_CLEAR = 8'h0e;
	localparam logic [7:0] CW_STAGING_UPDATE = 8'h0f;
	localparam logic [7:0] CW_SOFT_RESET = 8'h10;
	localparam logic [7:0] CW_SHAPING_SEED = 8'h11;
	localparam logic [7:0] CW_SAMPLE_LOAD = 8'h12;
	// data value that holds soft reset on
	localparam logic [7:0] SOFT_RESET_CODE = 8'h10;
	// status and enable bit positions
	localparam int BIT_FIFO_FULL = 6;
	localparam int BIT_FIFO_EMPTY = 5;
	localparam int BIT_FIFO_OVERFLOW = 4;
	localparam int BIT_FIFO_UNDERFLOW = 3;
	localparam int BIT_DIGITAL_LOCK = 2;
	localparam int BIT_ANALOG_LOCK = 1;
	localparam int BIT_RESET_DONE = 0;
	localparam logic [7:0] IRQ_USED_MASK = 8'h7f;
	// reset values
	localparam logic [7:0] RST_IRQ_STATUS = 8'h00;
	localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
	localparam logic [31:0] RST_CARRIER_INC = 32'h0000_0000;
	localparam logic [31:0] RST_SYMBOL_INC = 32'h0000_0000;
	localparam logic [31:0] RST_UPPER_CLAMP = 32'h07ff_ffff;
	localparam logic [31:0] RST_LOWER_CLAMP = 32'h0000_0000;
	localparam logic [18:0] RST_SHAPING_SEED = 19'h0_0000;
	localparam int SEED_W = 19;
	localparam int SAMPLE_W = 16;
endpackage

// File: test/mirqr_fifo_sink.sv
`timescale 1ns/1ps
// fifo side of the sample stream, stalls on request
module mirqr_fifo_sink (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic stall_i,
	output logic fifo_ready_o
);
	// ready is low in reset and while stalled
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			fifo_ready_o <= 1'b0;
		else
			fifo_ready_o <= !stall_i;
	end
endmodule

// File: test/mirqr_regs_chk.sv
`timescale 1ns/1ps
// port watcher for the register bank
module mirqr_regs_chk #(
	parameter int SAMPLE_W = 16
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [2:0] host_addr_i,
	input wire logic [7:0] control_data_bus_i,
	input wire logic [31:0] staging_buffer_o,
	input wire logic fifo_clear_pulse_o,
	input wire logic staging_update_pulse_o,
	input wire logic soft_reset_o,
	input wire logic sample_ready_o,
	input wire logic [SAMPLE_W-1:0] fifo_data_o,
	input wire logic fifo_valid_o,
	input wire logic fifo_ready_i
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	// strobes last one cycle and follow their transfer
	chk_clear_single: assert property (fifo_clear_pulse_o |=> !fifo_clear_pulse_o)
		else $error("clear pulse too long");
	chk_clear_cause: assert property (fifo_clear_pulse_o |-> $past(host_addr_i, 2) == 3'h4
		&& $past(control_data_bus_i, 2) == 8'h0e) else $error("clear pulse without write");
	chk_clear_flush: assert property (fifo_clear_pulse_o |-> ##[1:2] !fifo_valid_o)
		else $error("buffer not flushed");
	chk_update_single: assert property (staging_update_pulse_o |=> !staging_update_pulse_o)
		else $error("update pulse too long");
	chk_update_cause: assert property (staging_update_pulse_o |-> $past(host_addr_i, 2) == 3'h4
		&& $past(control_data_bus_i, 2) == 8'h0f) else $error("update pulse without write");
	chk_staging_still: assert property (!staging_update_pulse_o |=> $stable(staging_buffer_o))
		else $error("staging changed without update");
	// held word stays until taken
	chk_valid_holds: assert property (fifo_valid_o && !fifo_ready_i && !fifo_clear_pulse_o
		&& !soft_reset_o |=> fifo_valid_o && $stable(fifo_data_o)) else $error("word lost");
	chk_soft_unarmed: assert property (soft_reset_o && $past(soft_reset_o) |-> !sample_ready_o)
		else $error("loading armed in soft reset");
	chk_soft_cause: assert property ($changed(soft_reset_o) |-> $past(host_addr_i, 2) == 3'h4)
		else $error("soft reset moved without write");
	cover property (fifo_valid_o && !fifo_ready_i && !sample_ready_o);
	cover property (staging_update_pulse_o);
	cover property ($fell(soft_reset_o));
endmodule
bind mirqr_regs mirqr_regs_chk #(.SAMPLE_W(SAMPLE_W)) u_chk (.clk_sys_i, .rst_n_i,
	.host_addr_i, .control_data_bus_i, .staging_buffer_o, .fifo_clear_pulse_o,
	.staging_update_pulse_o, .soft_reset_o, .sample_ready_o, .fifo_data_o,
	.fifo_valid_o, .fifo_ready_i);

// File: test/tb_modulator_irq_nco_strobe_regs.sv
`timescale 1ns/1ps
module tb_modulator_irq_nco_strobe_regs;
	logic clk_sys_i = 0, rst_n_i = 0, ce_n = 1, wr_n = 1, strb = 0, stall = 1, hdrv = 0;
	logic [2:0] adr = 0;
	logic [7:0] hd = 0, cdo;
	logic [7:0] wl[6] = '{8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h11, 8'h09};
	logic [15:0] smp = 0, fd, sv[3];
	logic [15:0] q[$];
	logic [6:1] ev = 0;
	logic [31:0] car, sym, up, lo, stg, w, rnd = 32'h0000_ff9a, ex[6];
	logic [18:0] seed;
	logic oe, srdy, clr, upd, srst, irq, fv, frdy;
	int error_cnt = 0, comparisons = 0, nclr = 0, nupd = 0;
	// bus level: host while writing, else device, else a changed pattern
	wire logic [7:0] cdb = hdrv ? hd : (oe ? cdo : ~hd);
	always #12.5 clk_sys_i = !clk_sys_i;
	mirqr_regs dut (.clk_sys_i, .rst_n_i, .clk_en_i(1'b1), .host_ce_n_i(ce_n),
		.host_wr_n_i(wr_n), .host_addr_i(adr), .control_data_bus_i(cdb),
		.control_data_bus_o(cdo), .control_data_bus_oe_o(oe), .sample_bus_i(smp),
		.input_sample_strobe_i(strb), .sample_ready_o(srdy), .status_event_i(ev),
		.carrier_inc_o(car), .symbol_inc_o(sym), .upper_clamp_o(up), .lower_clamp_o(lo),
		.accumulator_seed_o(seed), .staging_buffer_o(stg), .fifo_clear_pulse_o(clr),
		.staging_update_pulse_o(upd), .soft_reset_o(srst), .irq_o(irq),
		.fifo_data_o(fd), .fifo_valid_o(fv), .fifo_ready_i(frdy));
	mirqr_fifo_sink sink (.clk_sys_i, .rst_n_i, .stall_i(stall), .fifo_ready_o(frdy));
	// popped words and strobe counts
	always @(posedge clk_sys_i)
	begin
		if (fv === 1'b1 && frdy === 1'b1)
			q.push_back(fd);
		nclr += (clr === 1'b1);
		nupd += (upd === 1'b1);
	end
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [31:0] msk(input logic [7:0] n);
		return n == 8'h11 ? 32'h0007_ffff : (n == 8'h09 ? 32'h0000_007f : 32'hffff_ffff);
	endfunction
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e)
		begin
			error_cnt++;
			$display("BAD %s exp %h saw %h", n, e, s);
		end
	endtask
	task automatic stop_test();
		$display("comparisons %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask
	// write cycle, pins held well past the synchroniser
	task automatic wr(input int a, input logic [7:0] d);
		cyc(1);
		adr = a[2:0];
		hd = d;
		hdrv = 1;
		ce_n = 0;
		wr_n = 0;
		cyc(4);
		wr_n = 1;
		cyc(4);
		ce_n = 1;
		hdrv = 0;
		cyc(4);
	endtask
	task automatic ld32(input logic [31:0] v);
		for (int i = 0; i < 4; i++)
			wr(i, v[8*i+:8]);
	endtask
	task automatic rd32(output logic [31:0] v);
		for (int i = 0; i < 4; i++)
		begin
			adr = i[2:0];
			ce_n = 0;
			cyc(5);
			chk("oe", oe, 1);
			v[8*i+:8] = cdo;
		end
		ce_n = 1;
		cyc(4);
	endtask
	task automatic push(input logic [15:0] d);
		smp = d;
		strb = 1;
		cyc(4);
		strb = 0;
		cyc(4);
	endtask
	// hang guard
	initial
	begin
		cyc(40000);
		error_cnt++;
		stop_test();
	end
	initial
	begin
		cyc(4);
		rst_n_i = 1;
		cyc(2);
		chk("car", car, 0);
		chk("sym", sym, 0);
		chk("up", up, 32'h07ff_ffff);
		chk("lo", lo, 0);
		chk("seed", seed, 0);
		rd32(w);
		chk("stat", w, 0);
		push(16'h1234);
		chk("unarm", fv, 0);
		// random words through the holding register, read back
		foreach (wl[i])
		begin
			rnd = nx(rnd);
			ex[i] = rnd & msk(wl[i]);
			ld32(rnd);
			wr(4, wl[i]);
			rd32(w);
			chk("rb", w, ex[i]);
		end
		chk("car", car, ex[0]);
		chk("sym", sym, ex[1]);
		chk("up", up, ex[2]);
		chk("lo", lo, ex[3]);
		chk("seed", seed, ex[4]);
		// each event: sticky, masked, cleared
		for (int b = 1; b < 7; b++)
		begin
			wr(0, 8'h7e);
			wr(4, 8'h09);
			ev[b] = 1;
			cyc(1);
			ev[b] = 0;
			cyc(2);
			chk("irq", irq, 1);
			wr(0, 8'h00);
			wr(4, 8'h08);
			rd32(w);
			chk("stat", w[7:0], 8'h01 << b);
			wr(4, 8'h09);
			chk("mask", irq, 0);
			wr(0, 8'h7f);
			wr(4, 8'h08);
			wr(0, 8'h7e);
			wr(4, 8'h09);
			chk("clr", irq, 0);
		end
		// soft reset held until another value at address 4
		wr(4, 8'h10);
		chk("srst", srst, 1);
		wr(1, 8'h10);
		chk("srst", srst, 1);
		wr(4, 8'h05);
		chk("srst", srst, 0);
		wr(0, 8'h00);
		wr(4, 8'h08);
		rd32(w);
		chk("done", w[0], 1);
		// staging bytes copied one per update
		rnd = nx(rnd);
		ld32(rnd);
		wr(4, 8'h0f);
		chk("stg1", stg[7:0], rnd[7:0]);
		repeat (3) wr(4, 8'h0f);
		chk("stg", stg, rnd);
		chk("nupd", nupd, 4);
		// fill while stalled, third dropped, then drain in order
		nclr = 0;
		wr(4, 8'h12);
		for (int i = 0; i < 3; i++)
		begin
			rnd = nx(rnd);
			sv[i] = rnd[15:0];
			push(sv[i]);
		end
		chk("full", srdy, 0);
		stall = 0;
		cyc(4);
		chk("n", q.size(), 2);
		chk("d0", q[0], sv[0]);
		chk("d1", q[1], sv[1]);
		stall = 1;
		push(16'h00a5);
		chk("held", fv, 1);
		chk("head", fd, 16'h00a5);
		// address 5 is refused, so no clear and the word stays
		wr(5, 8'h0e);
		chk("refuse", fv, 1);
		wr(4, 8'h0e);
		chk("flush", fv, 0);
		chk("nclr", nclr, 1);
		push(16'h5a5a);
		chk("disarm", fv, 0);
		chk("srdy0", srdy, 0);
		stop_test();
	end
endmodule
